// >>> pcsa_pkg.sv
// Constants and carrier types for the program counter, stack and indirect addressing block.
// Assumes a single core clock and an asynchronous active-high reset.
package pcsa_pkg;
    localparam int          PC_WIDTH        = 13;
    localparam int          STACK_DEPTH     = 8;
    localparam int          PTR_WIDTH       = 3;
    localparam int          TARGET_WIDTH    = 11;
    localparam int          DATA_ADDR_WIDTH = 9;
    localparam logic [7:0]  ADDR_INDIRECT   = 8'h00;
    localparam logic [7:0]  ADDR_PC_LOW     = 8'h02;
    localparam logic [7:0]  ADDR_STATUS     = 8'h03;
    localparam logic [7:0]  ADDR_POINTER    = 8'h04;
    localparam logic [7:0]  ADDR_UPPER      = 8'h0a;
    localparam logic [7:0]  ADDR_POWER      = 8'h8e;
    localparam int          PWR_POR_BIT     = 1;
    localparam int          PWR_BOR_BIT     = 0;
    localparam int          PWR_OSCF_BIT    = 3;
    localparam int          STATUS_BANK_BIT = 7;
    localparam int          PAGE_LSB        = 3;
    localparam logic [12:0] PC_RESET        = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR      = 13'h0004;
    localparam logic [7:0]  POINTER_RESET   = 8'h00;
    localparam logic [7:0]  UPPER_RESET     = 8'h00;
    localparam logic [7:0]  STATUS_RESET    = 8'h18;
    localparam logic [7:0]  READ_ZERO       = 8'h00;
    localparam logic        OSCF_RESET      = 1'b1;

    typedef enum logic [2:0]
    {
        PCSA_SEQ,
        PCSA_JUMP,
        PCSA_CALL,
        PCSA_RET,
        PCSA_IRQ,
        PCSA_HOLD
    } pcsa_flow_t;

    typedef struct packed
    {
        pcsa_flow_t                      flow;
        logic [TARGET_WIDTH-1:0]         target;
    } pcsa_ctl_t;

    typedef struct packed
    {
        logic       por;
        logic       bor;
        logic       external_reset_pin;
        logic       wdt;
    } pcsa_rst_cause_t;
endpackage : pcsa_pkg

// >>> pcsa_core.sv
// Program counter, return stack, power control and indirect data access.
// Assumes the decoder supplies flow controls and the data bus strobes on ref_clk.
//
// Behaviour
// - Power-on flag distinguishes power-on from other resets.
// - Brown-out flag separates brown-out from power-on.
// - Oscillator speed select bit in power control.
// - Software sets brown-out flag; clear means brown-out.
// - Brown-out flag unspecified when detection disabled.
// - Thirteen-bit counter gives next fetch address.
// - Counter low byte is read/write register; writes load it only while flow is PCSA_HOLD.
// - Upper counter bits written by software only through latch, never directly.
// - Counter addresses 8K contiguous program words.
// - Call and jump carry eleven-bit page target.
// - Page bits come from latch bits four, three.
// - Returns load full counter from stack.
// - Eight-entry thirteen-bit stack, hidden pointer.
// - Push on call or interrupt branch.
// - Pop on return, literal return, interrupt return.
// - Push and pop leave upper latch unchanged.
// - Stack wraps silently, overwriting oldest entries.
// - Indirect port accesses register named by pointer.
// - Indirect read with zero pointer returns zero.
// - Indirect write with zero pointer stores nothing.
// - Effective address is bank bit over pointer.
module pcsa_core
    import pcsa_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire pcsa_ctl_t                  ctl,
    input  wire pcsa_rst_cause_t            resetCause,
    input  wire logic                       brownoutDetectEnable,
    input  wire logic [7:0]                 regAddr,
    input  wire logic [7:0]                 regWrData,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic      [7:0]                 regRdData,
    output logic      [PC_WIDTH-1:0]        fetchAddr,
    output logic                            oscFastSelect,
    output logic      [DATA_ADDR_WIDTH-1:0] dataAddr,
    output logic      [7:0]                 dataWrData,
    output logic                            dataWrite,
    output logic                            dataRead,
    input  wire logic [7:0]                 dataRdData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [PC_WIDTH-1:0]        pc;
    logic [PC_WIDTH-1:0]        next_pc;
    logic [PC_WIDTH-1:0]        stack [STACK_DEPTH];
    logic [PTR_WIDTH-1:0]       stackPtr;
    logic [7:0]                 pcUpperLatch;
    logic [7:0]                 indirectPointer;
    logic [7:0]                 statusReg;
    logic                       powerOnFlag;
    logic                       brownoutFlag;
    logic                       oscFlag;
    logic                       readIndirect;
    logic [7:0]                 localRead;

    wire                        pushNow   = (ctl.flow == PCSA_CALL) || (ctl.flow == PCSA_IRQ);
    wire                        popNow    = (ctl.flow == PCSA_RET);
    wire  [PTR_WIDTH-1:0]       popPtr    = stackPtr - 3'h1;
    wire  [PC_WIDTH-1:0]        pcPlusOne = pc + 13'h0001;
    wire  [PC_WIDTH-1:0]        pagedTarget;
    wire                        hitIndirect = (regAddr == ADDR_INDIRECT);
    wire                        hitPcLow    = (regAddr == ADDR_PC_LOW);
    wire                        hitStatus   = (regAddr == ADDR_STATUS);
    wire                        hitPointer  = (regAddr == ADDR_POINTER);
    wire                        hitUpper    = (regAddr == ADDR_UPPER);
    wire                        hitPower    = (regAddr == ADDR_POWER);
    wire                        pointerZero = (indirectPointer == POINTER_RESET);
    wire  [7:0]                 powerValue  = {4'h0, oscFlag, 1'b0, powerOnFlag, brownoutFlag};
    wire  [7:0]                 localValue;

    assign pagedTarget = {pcUpperLatch[PAGE_LSB+1:PAGE_LSB], ctl.target};

    assign localValue = hitPcLow   ? pc[7:0] :
                        hitStatus  ? statusReg :
                        hitPointer ? indirectPointer :
                        hitUpper   ? pcUpperLatch :
                        hitPower   ? powerValue : READ_ZERO;

    assign dataAddr   = {statusReg[STATUS_BANK_BIT], indirectPointer};
    assign dataWrite  = regWrite && hitIndirect && !pointerZero;
    assign dataRead   = regRead && hitIndirect && !pointerZero;
    assign dataWrData = regWrData;
    assign fetchAddr  = pc;
    assign oscFastSelect = oscFlag;

    always_comb
    begin
        case (ctl.flow)
            PCSA_JUMP: next_pc = pagedTarget;
            PCSA_CALL: next_pc = pagedTarget;
            PCSA_IRQ:  next_pc = (ctl.target == '0) ? IRQ_VECTOR : pagedTarget;
            PCSA_RET:  next_pc = stack[popPtr];
            PCSA_HOLD: next_pc = pc;
            default:   next_pc = pcPlusOne;
        endcase
        if (regWrite && hitPcLow && ctl.flow == PCSA_HOLD)
        begin
            next_pc = {pcUpperLatch[4:0], regWrData};
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pc <= PC_RESET;
        end
        else
        begin
            pc <= next_pc;
        end
    end

    // Stack storage has no reset; the hidden pointer wraps modulo the depth.
    always_ff @(posedge ref_clk)
    begin
        if (pushNow)
        begin
            stack[stackPtr] <= pcPlusOne;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stackPtr <= '0;
        end
        else if (pushNow)
        begin
            stackPtr <= stackPtr + 3'h1;
        end
        else if (popNow)
        begin
            stackPtr <= popPtr;
        end
    end

    // The latch is written only by software, never by stack traffic.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pcUpperLatch    <= UPPER_RESET;
            indirectPointer <= POINTER_RESET;
            statusReg       <= STATUS_RESET;
        end
        else if (regWrite)
        begin
            if (hitUpper)
            begin
                pcUpperLatch <= {3'h0, regWrData[4:0]};
            end
            else if (hitPointer)
            begin
                indirectPointer <= regWrData;
            end
            else if (hitStatus)
            begin
                statusReg <= regWrData;
            end
        end
    end

    // The power-on and brown-out flags live in an always-on domain; the cause input says which reset occurred.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            oscFlag <= OSCF_RESET;
        end
        else if (regWrite && hitPower)
        begin
            oscFlag <= regWrData[PWR_OSCF_BIT];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (resetCause.por)
        begin
            powerOnFlag <= 1'b0;
        end
        else if (regWrite && hitPower)
        begin
            powerOnFlag <= regWrData[PWR_POR_BIT];
        end
        if (resetCause.bor && brownoutDetectEnable)
        begin
            brownoutFlag <= 1'b0;
        end
        else if (resetCause.por)
        begin
            brownoutFlag <= brownoutFlag;
        end
        else if (regWrite && hitPower)
        begin
            brownoutFlag <= regWrData[PWR_BOR_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            readIndirect <= 1'b0;
            localRead    <= READ_ZERO;
        end
        else
        begin
            readIndirect <= regRead && hitIndirect && !pointerZero;
            localRead    <= regRead ? localValue : READ_ZERO;
        end
    end

    assign regRdData = readIndirect ? dataRdData : localRead;
endmodule : pcsa_core

// >>> pcsa_ram_model.sv
// Data memory model behind the indirect access port.
// Assumes core strobes on ref_clk; answers one cycle after a read.
module pcsa_ram_model
    import pcsa_pkg::*;
(
    input  wire logic [DATA_ADDR_WIDTH-1:0] dataAddr,
    input  wire logic                       ref_clk,
    input  wire logic [7:0]                 dataWrData,
    input  wire logic                       dataWrite,
    input  wire logic                       dataRead,
    output logic      [7:0]                 dataRdData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [512];
    logic [7:0] word;
    logic       valid;
    always_ff @(posedge ref_clk)
    begin
        if (dataWrite) mem[dataAddr] <= dataWrData;
        word <= mem[dataAddr];
        valid <= dataRead;
    end
    // Outside the answer cycle the data lines show the inverse.
    assign dataRdData = valid ? word : ~word;
endmodule : pcsa_ram_model

// >>> pcsa_core_props.sv
// Concurrent checks on the ports of the core block.
// Assumes one clock domain; bound to every core instance.
module pcsa_core_props
    import pcsa_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire pcsa_ctl_t   ctl,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regRdData,
    input wire logic [12:0] fetchAddr,
    input wire logic        oscFastSelect,
    input wire logic [8:0]  dataAddr,
    input wire logic        dataWrite,
    input wire logic        dataRead
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire indRd = regRead && regAddr == ADDR_INDIRECT;
    wire indWr = regWrite && regAddr == ADDR_INDIRECT;
    property p_seq; ctl.flow == PCSA_SEQ |=> fetchAddr == 13'($past(fetchAddr) + 1); endproperty
    a_seq: assert property (p_seq) else $error("pc did not advance");
    property p_jump; ctl.flow == PCSA_JUMP |=> fetchAddr[10:0] == $past(ctl.target); endproperty
    a_jump: assert property (p_jump) else $error("jump target lost");
    property p_ret; ctl.flow == PCSA_CALL ##1 ctl.flow == PCSA_RET
        |=> fetchAddr == 13'($past(fetchAddr, 2) + 1); endproperty
    a_ret: assert property (p_ret) else $error("return address wrong");
    property p_pcl; regWrite && regAddr == ADDR_PC_LOW && ctl.flow == PCSA_HOLD
        |=> fetchAddr[7:0] == $past(regWrData); endproperty
    a_pcl: assert property (p_pcl) else $error("pc low write lost");
    property p_osc; regWrite && regAddr == ADDR_POWER
        |=> oscFastSelect == $past(regWrData[PWR_OSCF_BIT]); endproperty
    a_osc: assert property (p_osc) else $error("speed select wrong");
    property p_ind0; indRd && dataAddr[7:0] == 8'h00 |-> !dataRead ##1 regRdData == READ_ZERO;
    endproperty
    a_ind0: assert property (p_ind0) else $error("self read not zero");
    property p_wr0; indWr && dataAddr[7:0] == 8'h00 |-> !dataWrite; endproperty
    a_wr0: assert property (p_wr0) else $error("self write stored");
    property p_ind; indRd && dataAddr[7:0] != 8'h00 |-> dataRead; endproperty
    a_ind: assert property (p_ind) else $error("indirect read missing");
    c_calls: cover property (ctl.flow == PCSA_CALL [*8]);
    c_rets: cover property (ctl.flow == PCSA_RET [*8]);
    c_bank: cover property (indRd && dataAddr[8]);
endmodule : pcsa_core_props

bind pcsa_core pcsa_core_props u_props (.*);

// >>> pcsa_core_bench.sv
// Self-checking bench for the core block with a data memory model.
// Assumes a 10 MHz clock and a ten cycle reset at the start.
module pcsa_core_bench
    import pcsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst = 1, regWrite = 0, regRead = 0;
    pcsa_ctl_t ctl = '{PCSA_HOLD, 11'h000};
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, dataWrData, dataRdData;
    logic [12:0] fetchAddr;
    logic [8:0] dataAddr;
    logic oscFastSelect, dataWrite, dataRead;
    pcsa_rst_cause_t resetCause = '0;
    logic brownoutDetectEnable = 1'b1;
    int fails = 0, comparisons = 0;
    pcsa_core u_dut (.ref_clk, .rst, .ctl, .resetCause, .brownoutDetectEnable,
        .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .fetchAddr, .oscFastSelect, .dataAddr, .dataWrData, .dataWrite, .dataRead, .dataRdData);
    pcsa_ram_model u_ram (.ref_clk, .dataAddr, .dataWrData, .dataWrite, .dataRead, .dataRdData);
    initial forever #50 ref_clk = ~ref_clk;
    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [12:0] seen, input logic [12:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a,
        input logic [7:0] m, input logic [7:0] e);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        chk(n, 13'(regRdData & m), 13'(e));
    endtask : rd
    task automatic step(input pcsa_flow_t f, input logic [10:0] t);
        @(posedge ref_clk);
        ctl <= '{f, t};
        @(negedge ref_clk);
    endtask : step
    task automatic t_power;
        chk("reset pc", fetchAddr, PC_RESET);
        chk("reset speed", 13'(oscFastSelect), 13'(OSCF_RESET));
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_POWER, i ? 8'h08 : 8'h01);
            rd("power", ADDR_POWER, 8'h09, i ? 8'h08 : 8'h01);
            chk("speed", 13'(oscFastSelect), 13'(i));
        end
        $display("power test done");
    endtask : t_power
    task automatic t_flow;
        wr(ADDR_UPPER, 8'h18);
        wr(ADDR_PC_LOW, 8'h5a);
        @(negedge ref_clk);
        chk("pc low load", fetchAddr, 13'h185a);
        rd("pc low", ADDR_PC_LOW, 8'hff, 8'h5a);
        step(PCSA_JUMP, 11'h123);
        step(PCSA_SEQ, 11'h000);
        chk("jump", fetchAddr, 13'h1923);
        step(PCSA_SEQ, 11'h000);
        step(PCSA_HOLD, 11'h000);
        chk("advance", fetchAddr, 13'h1925);
        for (int k = 0; k < 9; k++) step(PCSA_CALL, 11'(11'h100 + k));
        for (int j = 0; j < 10; j++)
        begin
            step(j < 9 ? PCSA_RET : PCSA_HOLD, 11'h000);
            if (j > 0) chk("return", fetchAddr, 13'(13'h1900 + (j == 9 ? 8 : 9 - j)));
        end
        step(PCSA_IRQ, 11'h000);
        step(PCSA_RET, 11'h000);
        chk("irq vector", fetchAddr, 13'h0004);
        step(PCSA_HOLD, 11'h000);
        chk("irq return", fetchAddr, 13'h1909);
        rd("latch kept", ADDR_UPPER, 8'hff, 8'h18);
        $display("flow test done");
    endtask : t_flow
    task automatic t_indirect;
        wr(ADDR_POINTER, 8'h20);
        wr(ADDR_INDIRECT, 8'hc3);
        rd("indirect", ADDR_INDIRECT, 8'hff, 8'hc3);
        wr(ADDR_STATUS, 8'h98);
        wr(ADDR_INDIRECT, 8'h3c);
        rd("bank one", ADDR_INDIRECT, 8'hff, 8'h3c);
        wr(ADDR_STATUS, 8'h18);
        rd("bank zero", ADDR_INDIRECT, 8'hff, 8'hc3);
        wr(ADDR_POINTER, 8'h00);
        wr(ADDR_INDIRECT, 8'hff);
        rd("self read", ADDR_INDIRECT, 8'hff, 8'h00);
        $display("indirect test done");
    endtask : t_indirect
    task automatic pulse_cause(input pcsa_rst_cause_t c);
        @(posedge ref_clk);
        resetCause <= c;
        @(posedge ref_clk);
        resetCause <= '0;
    endtask : pulse_cause
    task automatic t_cause;
        wr(ADDR_POWER, 8'h0b);
        rd("flags set", ADDR_POWER, 8'h0b, 8'h0b);
        @(posedge ref_clk);
        rst <= 1'b1;
        resetCause <= '{por: 1'b1, default: 1'b0};
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        resetCause <= '0;
        @(negedge ref_clk);
        chk("second reset pc", fetchAddr, PC_RESET);
        chk("second reset speed", 13'(oscFastSelect), 13'(OSCF_RESET));
        rd("power-on flag", ADDR_POWER, 8'h02, 8'h00);
        wr(ADDR_POWER, 8'h0b);
        pulse_cause('{bor: 1'b1, default: 1'b0});
        rd("brown-out", ADDR_POWER, 8'h03, 8'h02);
        @(posedge ref_clk);
        brownoutDetectEnable <= 1'b0;
        wr(ADDR_POWER, 8'h0b);
        pulse_cause('{bor: 1'b1, default: 1'b0});
        rd("detect off", ADDR_POWER, 8'h0a, 8'h0a);
        $display("reset cause test done");
    endtask : t_cause
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        t_power;
        t_flow;
        t_indirect;
        t_cause;
        complete_run;
    end
    initial
    begin
        #200000;
        fails++;
        complete_run;
    end
endmodule : pcsa_core_bench
